// ===== shared/adc_avg_regs.vh
// constants for the four-channel converter averaging block
// assumes inclusion by bare name from design files
`ifndef ADC_AVG_REGS_VH
`define ADC_AVG_REGS_VH

`define NUM_CHANNELS        4
`define SAMPLE_WIDTH        32
`define AVG_TAPS            16
`define AVG_SHIFT           4
`define SUM_WIDTH           36
`define CLOCK_DIVIDE        2
`define OVERSAMPLING_RATIO  2048
`define RATIO_WIDTH         11
`define RATIO_LAST          11'h7ff
`define RATIO_ZERO          11'h000
`define SAMPLE_RATE_HZ      3000
`define SAMPLE_PERIOD_US    333
`define CONV_CLOCK_MAX_KHZ  6500
`define SYS_CLOCK_KHZ       12288
`define SAMPLE_ZERO         32'h0000_0000
`define SUM_ZERO            36'h0_0000_0000
`define INDEX_ZERO          4'h0
`define INDEX_STEP          4'h1

`endif

// ===== core/moving_average.v
// one channel of a 16-tap equal-weight moving average
// assumes sample_valid pulses once per completed conversion
`timescale 1ns/1ps
`include "adc_avg_regs.vh"

module moving_average (
  // clock and reset
  input  wire                       clk_sys,
  input  wire                       rstn,
  // incoming sample
  input  wire                       sample_valid,
  input  wire signed [31:0]         sample_in,
  // averaged result
  output reg  signed [31:0]         average_out
);

  // ******************************************************
  // history and running sum
  // ******************************************************
  reg signed  [`SAMPLE_WIDTH-1:0] history [0:`AVG_TAPS-1];
  reg         [`AVG_SHIFT-1:0]    write_index;
  reg signed  [`SUM_WIDTH-1:0]    running_sum;
  wire signed [`SUM_WIDTH-1:0]    next_sum;
  integer                         i;

  // sign-extend one sample to the sum width
  function signed [`SUM_WIDTH-1:0] widen;
    input signed [`SAMPLE_WIDTH-1:0] value;
    begin
      widen = {{(`SUM_WIDTH-`SAMPLE_WIDTH){value[`SAMPLE_WIDTH-1]}}, value};
    end
  endfunction

  // add newest, drop oldest; 36 bits hold sixteen 32-bit values
  assign next_sum = running_sum + widen(sample_in) - widen(history[write_index]);

  always @(posedge clk_sys) begin
    if (!rstn) begin
      for (i = 0; i < `AVG_TAPS; i = i + 1)
        history[i] <= `SAMPLE_ZERO;
      write_index <= `INDEX_ZERO;
      running_sum <= `SUM_ZERO;
      average_out <= `SAMPLE_ZERO;
    end else if (sample_valid) begin
      history[write_index] <= sample_in;
      write_index          <= write_index + `INDEX_STEP;
      running_sum          <= next_sum;
      // divide by 16 as arithmetic shift, sign kept
      average_out          <= next_sum[`SUM_WIDTH-1:`AVG_SHIFT];
    end
  end

endmodule // moving_average

// ===== core/adc_averaging.v
// four-channel converter control and moving-average smoothing
// assumes a 12.288 MHz system clock and converter results valid on done pulse
// assumes start may stay high; only the first high cycle after reset counts
// assumes every converter channel finishes on the same shared done pulse
//
// Function
// - start all converter channels together with one shared completion path
// - run channels continuously after one start, no delay between conversions
// - raise a completion event when each conversion finishes
// - oversampling ratio is 2048 modulator clocks per output sample
// - converter clock is system clock divided by two
// - output samples at 3000 Hz, one event about every 333 us
// - input gain stage of every channel stays disabled
// - each channel outputs equal-weight average of last N samples
// - averaging length N is 16 samples
// - N power of two: running sum then arithmetic right shift
`timescale 1ns/1ps
`include "adc_avg_regs.vh"

module adc_averaging (
  // clock and reset
  input  wire                       clk_sys,
  input  wire                       rstn,
  // converter control
  input  wire                       start,
  output reg                        conv_clock,
  output reg                        conv_start,
  // converter configuration
  output wire                       continuous_mode,
  output wire                       input_gain_stage_enable,
  output wire [10:0]                oversampling_ratio,
  // launch status
  output reg                        running,
  // converter results
  input  wire                       conv_done,
  input  wire signed [31:0]         result0,
  input  wire signed [31:0]         result1,
  input  wire signed [31:0]         result2,
  input  wire signed [31:0]         result3,
  // averaged stream
  output reg                        sample_event,
  output reg                        average_valid,
  output wire signed [31:0]         average0,
  output wire signed [31:0]         average1,
  output wire signed [31:0]         average2,
  output wire signed [31:0]         average3
);

  // ******************************************************
  // static configuration
  // ******************************************************
  assign continuous_mode         = 1'b1;
  assign input_gain_stage_enable = 1'b0;

  // ******************************************************
  // oversampling ratio, sent as ratio minus one
  // ******************************************************
  assign oversampling_ratio      = `RATIO_LAST;

  // ******************************************************
  // converter clock, divide by two
  // ******************************************************
  reg next_conv_clock;

  always @* begin
    next_conv_clock = ~conv_clock;
  end

  always @(posedge clk_sys) begin
    if (!rstn)
      conv_clock <= 1'b0;
    else
      conv_clock <= next_conv_clock;
  end

  // ******************************************************
  // single start, then free running
  // ******************************************************
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_LAUNCH = 2'b01;
  localparam [1:0] ST_RUN    = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg       next_conv_start;
  reg       next_running;

  // ******************************************************
  // launch decision
  // ******************************************************
  // a held start must not relaunch, so only the idle
  // state answers it; reset is the only way back
  always @* begin
    next_state      = state;
    next_conv_start = 1'b0;
    next_running    = running;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state      = ST_LAUNCH;
          next_conv_start = 1'b1; // one shared start for all channels
          next_running    = 1'b1;
        end
      end

      ST_LAUNCH: begin
        next_state   = ST_RUN;
        next_running = 1'b1;
      end

      ST_RUN: begin
        next_state   = ST_RUN; // later starts ignored
        next_running = 1'b1;
      end

      default: begin
        next_state   = ST_IDLE;
        next_running = 1'b0;
      end
    endcase
  end

  // ******************************************************
  // launch registers
  // ******************************************************
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state      <= ST_IDLE;
      conv_start <= 1'b0;
      running    <= 1'b0;
    end else begin
      state      <= next_state;
      conv_start <= next_conv_start;
      running    <= next_running;
    end
  end

  // ******************************************************
  // completion event, one path for all channels
  // ******************************************************
  // one accept decision shared by every channel
  function event_accept;
    input done;
    input live;
    begin
      event_accept = done & live;
    end
  endfunction

  // results stand only with the done pulse, so every
  // filter takes them in that same cycle
  wire accept;
  assign accept = event_accept(conv_done, running);

  // ******************************************************
  // averaged stream strobes
  // ******************************************************
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sample_event  <= 1'b0;
      average_valid <= 1'b0;
    end else begin
      sample_event  <= accept;
      average_valid <= sample_event;
    end
  end

  // ******************************************************
  // channel 0 filter
  // ******************************************************
  moving_average u_avg0 (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .sample_valid (accept),
    .sample_in    (result0),
    .average_out  (average0)
  );

  // ******************************************************
  // channel 1 filter
  // ******************************************************
  moving_average u_avg1 (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .sample_valid (accept),
    .sample_in    (result1),
    .average_out  (average1)
  );

  // ******************************************************
  // channel 2 filter
  // ******************************************************
  moving_average u_avg2 (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .sample_valid (accept),
    .sample_in    (result2),
    .average_out  (average2)
  );

  // ******************************************************
  // channel 3 filter
  // ******************************************************
  moving_average u_avg3 (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .sample_valid (accept),
    .sample_in    (result3),
    .average_out  (average3)
  );

endmodule // adc_averaging

// ===== tb/adc_averaging_asserts.sv
// port checker for the averaging block
// assumes binding onto adc_averaging
`timescale 1ns/1ps
module adc_averaging_asserts (
  input wire clk_sys, rstn, start, conv_clock, conv_start, continuous_mode, running,
  input wire input_gain_stage_enable, conv_done, sample_event, average_valid,
  input wire [10:0] oversampling_ratio,
  input wire signed [31:0] average0
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_launch; conv_start && running ##1 !conv_start; endsequence
  sequence s_result; sample_event ##1 average_valid; endsequence
  a_clock_half: assert property ($past(rstn) |-> conv_clock != $past(conv_clock))
    else $error("converter clock not halved");
  a_single_launch: assert property (start && !running |=> s_launch)
    else $error("launch missing");
  a_no_restart: assert property (running |=> !conv_start)
    else $error("second launch");
  a_cont_mode: assert property (continuous_mode == 1'b1)
    else $error("not continuous");
  a_gain_off: assert property (input_gain_stage_enable == 1'b0)
    else $error("gain stage on");
  a_ratio_fixed: assert property (oversampling_ratio == 11'h7ff)
    else $error("wrong ratio");
  a_event_done: assert property (conv_done && running |=> s_result)
    else $error("event missing");
  a_no_event: assert property (!(conv_done && running) |=> !sample_event)
    else $error("spurious event");
  a_hold_avg: assert property (!sample_event |-> $stable(average0))
    else $error("average moved");
endmodule // adc_averaging_asserts
bind adc_averaging adc_averaging_asserts chk (.*);

// ===== tb/converter_model.sv
// four converter channels sharing one done pulse
// assumes a shortened period; results only valid with done
`timescale 1ns/1ps
module converter_model #(parameter PERIOD = 8) (
  input wire clk_sys, rstn, conv_start,
  input wire [127:0] smp,
  output reg conv_done = 1'b0,
  output reg [31:0] result0 = 32'h0, result1 = 32'h0, result2 = 32'h0, result3 = 32'h0
);
  reg on = 1'b0;
  reg [7:0] cnt = 8'h0;
  wire live = conv_start || on;
  wire last = cnt == PERIOD - 1;
  always @(negedge clk_sys) begin
    on <= rstn && live;
    cnt <= (!rstn || !live || last) ? 8'h0 : cnt + 8'h1;
    conv_done <= rstn && live && last;
    if (rstn && live && last)
      {result3, result2, result1, result0} <= smp;
    else
      {result3, result2, result1, result0} <= ~{result3, result2, result1, result0};
  end
endmodule // converter_model

// ===== tb/tb_adc_averaging.sv
// testbench for adc_averaging with converter model
// assumes design and model connect by matching names
`timescale 1ns/1ps
module tb_adc_averaging;
  reg clk_sys = 1'b0, rstn = 1'b0, start = 1'b0;
  reg [127:0] smp = 128'h0;
  reg signed [31:0] h [0:3][0:15];
  wire conv_clock, conv_start, continuous_mode, input_gain_stage_enable, running;
  wire conv_done, sample_event, average_valid;
  wire [10:0] oversampling_ratio;
  wire signed [31:0] result0, result1, result2, result3, average0, average1, average2, average3;
  wire [127:0] avg = {average3, average2, average1, average0};
  integer fails = 0, checks_done = 0, i, c, k, e;
  always #50 clk_sys = ~clk_sys;
  converter_model model (.*);
  adc_averaging dut (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task clr;
    for (c = 0; c < 64; c = c + 1) h[c / 16][c % 16] = 32'h0;
  endtask
  // history shift, 36-bit sum, sign-kept shift by four
  task push_check;
    reg signed [35:0] sum;
    for (c = 0; c < 4; c = c + 1) begin
      for (i = 15; i > 0; i = i - 1) h[c][i] = h[c][i - 1];
      h[c][0] = smp[c * 32 +: 32];
      sum = 36'h0;
      for (i = 0; i < 16; i = i + 1) sum = sum + h[c][i];
      chk(avg[c * 32 +: 32], sum[35:4]);
    end
  endtask
  // extremes and negatives, successive averaged events eight cycles apart
  task t_stream(input integer cnt);
    for (e = 0; e < cnt; e = e + 1) begin
      k = 0;
      @(negedge clk_sys);
      while (sample_event !== 1'b1 && k < 40) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      chk(k < 40, 32'h1);
      push_check;
      @(negedge clk_sys);
      chk(average_valid, 32'h1);
      smp <= {32'hffffffff - e, e[0] ? 32'h12345678 : 32'hfffff000, 32'h80000000 + e, 32'h7fffffff - e};
    end
  endtask
  // reset mid-run clears history, then relaunch
  task t_reset;
    begin
      rstn <= 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(|avg | running, 32'h0);
      chk(conv_clock | conv_start | sample_event | average_valid, 32'h0);
      chk(oversampling_ratio, 32'h7ff);
      chk(continuous_mode, 32'h1);
      chk(input_gain_stage_enable, 32'h0);
      rstn <= 1'b1;
      clr;
      t_stream(3);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    clr;
    repeat (6) @(negedge clk_sys);
    rstn <= 1'b1;
    start <= 1'b1;
    t_stream(20);
    t_reset;
    test_done;
  end
  initial begin
    #400000;
    fails = fails + 1;
    test_done;
  end
endmodule // tb_adc_averaging
